// ==== verilog/cmo_cfg.svh ====
// Constants for the cache maintenance operation unit
`ifndef CMO_CFG_SVH
`define CMO_CFG_SVH
`define CMO_XLEN 32
`define CMO_IMM_W 16
`define CMO_TGT_LSB 16
`define CMO_TGT_MSB 17
`define CMO_OP_LSB 18
`define CMO_OP_MSB 20
`define CMO_BASE_LSB 21
`define CMO_BASE_MSB 25
`define CMO_LINE_OFFSET_BIT 5
`define CMO_SET_INDEX_TOP_BIT 13
`define CMO_WAY_SELECT_TOP_BIT 15
`define CMO_CCA_W 3
`define CMO_CCA_COHERENT_A 3'h4
`define CMO_CCA_COHERENT_B 3'h5
`define CMO_FLUSH_STEPS 2'h2
`define CMO_WATCH_ON 1'b0
`define CMO_KSEG_CHECK 1'b1
`define CMO_INDEX_FROM_PA 1'b0
`endif

// ==== verilog/cmo_pkg.sv ====
// Types for the cache maintenance operation unit
package cmo_pkg;
	typedef enum logic [1:0] {
		CMO_TGT_PRI_INSTR = 2'b00,
		CMO_TGT_PRI_DATA = 2'b01,
		CMO_TGT_TERTIARY = 2'b10,
		CMO_TGT_SECONDARY = 2'b11
	} cmo_target_t;
	typedef enum logic [2:0] {
		CMO_OP_IDX_INV = 3'b000,
		CMO_OP_IDX_LOAD_TAG = 3'b001,
		CMO_OP_IDX_STORE_TAG = 3'b010,
		CMO_OP_IMPL = 3'b011,
		CMO_OP_HIT_INV = 3'b100,
		CMO_OP_HIT_FILL_WBINV = 3'b101,
		CMO_OP_HIT_WB = 3'b110,
		CMO_OP_FETCH_LOCK = 3'b111
	} cmo_op_t;
	typedef enum logic [2:0] {
		CMO_ST_IDLE = 3'b000,
		CMO_ST_XLATE = 3'b001,
		CMO_ST_INNER = 3'b010,
		CMO_ST_REQ = 3'b011,
		CMO_ST_DONE = 3'b100
	} cmo_state_t;
	typedef enum logic [2:0] {
		CMO_EXC_NONE = 3'b000,
		CMO_EXC_TLB_REFILL = 3'b001,
		CMO_EXC_TLB_INVALID = 3'b010,
		CMO_EXC_ADDR_ERR = 3'b011,
		CMO_EXC_CACHE_ERR = 3'b100,
		CMO_EXC_BUS_ERR = 3'b101
	} cmo_exc_t;
endpackage

// ==== verilog/cmo_unit.sv ====
// Cache maintenance operation unit: decode, address, translation, request sequencing
`include "cmo_cfg.svh"
module cmo_unit (
	input wire logic clk_i, // Core clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic issue_valid_i, // Instruction presented
	input wire logic [31:0] instr_i, // Instruction word
	input wire logic [31:0] base_value_i, // Value of selected base register
	input wire logic phys_cache_i, // Target cache is physically addressed
	input wire logic direct_mapped_i, // Target cache is direct-mapped
	input wire logic wb_data_cache_i, // Data cache is write-back
	input wire logic kernel_fault_i, // Address lies in faulting kernel region
	input wire logic mmu_done_i, // Translation answer valid
	input wire logic [31:0] mmu_pa_i, // Translated physical address
	input wire logic mmu_refill_i, // Translation missed
	input wire logic mmu_invalid_i, // Translation entry invalid
	input wire logic [2:0] mmu_cca_i, // Cacheability attribute of address
	input wire logic ctl_done_i, // Cache controller finished request
	input wire logic ctl_cache_err_i, // Controller saw cache or bus error on writeback
	input wire logic ctl_bus_err_i, // Bus transaction terminated in error
	input wire logic barrier_idle_i, // Outstanding memory traffic drained
	output logic busy_o, // Instruction held
	output logic mmu_req_o, // Translation request
	output logic [31:0] mmu_va_o, // Address to translate
	output logic ctl_req_o, // Request to cache controller
	output logic [2:0] ctl_op_o, // Operation code
	output logic [1:0] ctl_target_o, // Target cache
	output logic [31:0] ctl_addr_o, // Lookup address
	output logic [1:0] ctl_way_o, // Way for index operations
	output logic [7:0] ctl_index_o, // Set index for index operations
	output logic ctl_index_mode_o, // Request uses way/index pointer
	output logic ctl_broadcast_o, // Broadcast to coherent caches
	output logic ctl_keep_valid_o, // Leave line valid with dirty cleared
	output logic ctl_no_cache_err_o, // Suppress cache error reporting
	output logic watch_hit_o, // Data watch trigger
	output logic done_o, // Instruction retired, one cycle
	output logic exc_valid_o, // Exception raised, one cycle
	output logic [2:0] exc_code_o // Exception kind
);

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

function automatic logic [31:0] eff_addr(input logic [31:0] base, input logic [15:0] imm);
	eff_addr = base + {{16{imm[15]}}, imm};
endfunction

function automatic logic is_index_op(input logic [2:0] op);
	is_index_op = (op[2] == 1'b0) && (op != 3'h3);
endfunction

function automatic logic is_coherent(input logic [2:0] cca);
	is_coherent = (cca == `CMO_CCA_COHERENT_A) || (cca == `CMO_CCA_COHERENT_B);
endfunction

////////////////////////////////////////////////////////////////////////////////
// Captured instruction

cmo_pkg::cmo_state_t state_ff;
cmo_pkg::cmo_state_t nxt_state;
logic [2:0] op_ff;
logic [1:0] tgt_ff;
logic [31:0] ea_ff;
logic [31:0] pa_ff;
logic bcast_ff;
logic inner_ff;
logic [2:0] op_in;
logic [1:0] tgt_in;
logic idx_op;
logic [31:0] sel_addr;

assign op_in = instr_i[`CMO_OP_MSB:`CMO_OP_LSB];
assign tgt_in = instr_i[`CMO_TGT_MSB:`CMO_TGT_LSB];
assign idx_op = is_index_op(op_ff);
// Index ops use the untranslated address by default hit ops pick by cache kind
assign sel_addr = idx_op ? (`CMO_INDEX_FROM_PA ? pa_ff : ea_ff) : (phys_cache_i ? pa_ff : ea_ff);

always_ff @(posedge clk_i) begin
	if (reset_i) begin
		op_ff <= 3'h0;
		tgt_ff <= 2'h0;
		ea_ff <= 32'h0;
	end else if (state_ff == cmo_pkg::CMO_ST_IDLE && issue_valid_i) begin
		op_ff <= op_in;
		tgt_ff <= tgt_in;
		ea_ff <= eff_addr(base_value_i, instr_i[15:0]);
	end
end

always_ff @(posedge clk_i) begin
	if (reset_i) begin
		pa_ff <= 32'h0;
		bcast_ff <= 1'b0;
	end else if (state_ff == cmo_pkg::CMO_ST_XLATE && mmu_done_i) begin
		pa_ff <= mmu_pa_i;
		// One choice for every level the instruction touches
		bcast_ff <= !is_index_op(op_ff) && op_ff != 3'h3 && is_coherent(mmu_cca_i);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

logic xlate_fault;
assign xlate_fault = mmu_refill_i || mmu_invalid_i || (`CMO_KSEG_CHECK && kernel_fault_i);

always_comb begin
	nxt_state = state_ff;
	case (state_ff)
		cmo_pkg::CMO_ST_IDLE: begin
			if (issue_valid_i)
				nxt_state = cmo_pkg::CMO_ST_XLATE;
		end
		cmo_pkg::CMO_ST_XLATE: begin
			if (mmu_done_i)
				nxt_state = xlate_fault ? cmo_pkg::CMO_ST_IDLE : cmo_pkg::CMO_ST_INNER;
		end
		cmo_pkg::CMO_ST_INNER: begin
			if (ctl_done_i || ctl_cache_err_i || ctl_bus_err_i || !inner_ff)
				nxt_state = (inner_ff && !ctl_done_i) ? cmo_pkg::CMO_ST_IDLE : cmo_pkg::CMO_ST_REQ;
		end
		cmo_pkg::CMO_ST_REQ: begin
			if (ctl_cache_err_i || ctl_bus_err_i)
				nxt_state = cmo_pkg::CMO_ST_IDLE;
			else if (ctl_done_i)
				nxt_state = cmo_pkg::CMO_ST_DONE;
		end
		cmo_pkg::CMO_ST_DONE: begin
			if (barrier_idle_i)
				nxt_state = cmo_pkg::CMO_ST_IDLE;
		end
		default: nxt_state = cmo_pkg::CMO_ST_IDLE;
	endcase
end

always_ff @(posedge clk_i) begin
	if (reset_i)
		state_ff <= cmo_pkg::CMO_ST_IDLE;
	else
		state_ff <= nxt_state;
end

// Outer-level targets first run the same operation on primary data
always_ff @(posedge clk_i) begin
	if (reset_i)
		inner_ff <= 1'b0;
	else if (state_ff == cmo_pkg::CMO_ST_IDLE && issue_valid_i)
		inner_ff <= tgt_in[1];
	else if (state_ff == cmo_pkg::CMO_ST_INNER && ctl_done_i)
		inner_ff <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Outputs

logic err_ok;
assign err_ok = (op_ff != 3'h1) && (op_ff != 3'h2);

always_ff @(posedge clk_i) begin
	if (reset_i) begin
		mmu_req_o <= 1'b0;
		mmu_va_o <= 32'h0;
	end else begin
		mmu_req_o <= (nxt_state == cmo_pkg::CMO_ST_XLATE) && !(state_ff == cmo_pkg::CMO_ST_XLATE && mmu_done_i);
		mmu_va_o <= (state_ff == cmo_pkg::CMO_ST_IDLE) ? eff_addr(base_value_i, instr_i[15:0]) : ea_ff;
	end
end

logic req_phase;
assign req_phase = (state_ff == cmo_pkg::CMO_ST_INNER && inner_ff) || state_ff == cmo_pkg::CMO_ST_REQ;

always_ff @(posedge clk_i) begin
	if (reset_i) begin
		ctl_req_o <= 1'b0;
		ctl_op_o <= 3'h0;
		ctl_target_o <= 2'h0;
		ctl_addr_o <= 32'h0;
		ctl_way_o <= 2'h0;
		ctl_index_o <= 8'h0;
		ctl_index_mode_o <= 1'b0;
		ctl_broadcast_o <= 1'b0;
		ctl_keep_valid_o <= 1'b0;
		ctl_no_cache_err_o <= 1'b0;
	end else begin
		ctl_req_o <= req_phase && !ctl_done_i && !ctl_cache_err_i && !ctl_bus_err_i;
		ctl_op_o <= op_ff;
		ctl_target_o <= (state_ff == cmo_pkg::CMO_ST_INNER) ? 2'h1 : tgt_ff;
		ctl_addr_o <= sel_addr;
		ctl_index_o <= sel_addr[`CMO_SET_INDEX_TOP_BIT-1:`CMO_LINE_OFFSET_BIT];
		ctl_way_o <= direct_mapped_i ? 2'h0 : sel_addr[`CMO_WAY_SELECT_TOP_BIT-1:`CMO_SET_INDEX_TOP_BIT];
		ctl_index_mode_o <= idx_op;
		ctl_broadcast_o <= bcast_ff;
		ctl_keep_valid_o <= (op_ff == 3'h6) && wb_data_cache_i;
		ctl_no_cache_err_o <= !err_ok;
	end
end

always_ff @(posedge clk_i) begin
	if (reset_i) begin
		busy_o <= 1'b0;
		done_o <= 1'b0;
		watch_hit_o <= 1'b0;
	end else begin
		busy_o <= nxt_state != cmo_pkg::CMO_ST_IDLE;
		done_o <= state_ff == cmo_pkg::CMO_ST_DONE && barrier_idle_i;
		watch_hit_o <= `CMO_WATCH_ON && done_o;
	end
end

always_ff @(posedge clk_i) begin
	if (reset_i) begin
		exc_valid_o <= 1'b0;
		exc_code_o <= cmo_pkg::CMO_EXC_NONE;
	end else begin
		exc_valid_o <= 1'b0;
		exc_code_o <= cmo_pkg::CMO_EXC_NONE;
		if (state_ff == cmo_pkg::CMO_ST_XLATE && mmu_done_i && xlate_fault) begin
			exc_valid_o <= 1'b1;
			// Only load-type causes exist here; no alignment check at all
			if (mmu_refill_i)
				exc_code_o <= cmo_pkg::CMO_EXC_TLB_REFILL;
			else if (mmu_invalid_i)
				exc_code_o <= cmo_pkg::CMO_EXC_TLB_INVALID;
			else
				exc_code_o <= cmo_pkg::CMO_EXC_ADDR_ERR;
		end else if (req_phase && !ctl_done_i && ctl_bus_err_i) begin
			exc_valid_o <= 1'b1;
			exc_code_o <= cmo_pkg::CMO_EXC_BUS_ERR;
		end else if (req_phase && !ctl_done_i && ctl_cache_err_i) begin
			exc_valid_o <= err_ok;
			exc_code_o <= err_ok ? cmo_pkg::CMO_EXC_CACHE_ERR : cmo_pkg::CMO_EXC_NONE;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Checks

AST_EA_SIGNEXT: assert property (@(posedge clk_i) disable iff (reset_i)
	state_ff == cmo_pkg::CMO_ST_IDLE && issue_valid_i |=> ea_ff == $past(base_value_i) + {{16{$past(instr_i[15])}}, $past(instr_i[15:0])})
	else $error("effective address wrong");
AST_TGT_DECODE: assert property (@(posedge clk_i) disable iff (reset_i)
	state_ff == cmo_pkg::CMO_ST_IDLE && issue_valid_i |=> tgt_ff == $past(instr_i[17:16]))
	else $error("target field wrong");
AST_OP_DECODE: assert property (@(posedge clk_i) disable iff (reset_i)
	state_ff == cmo_pkg::CMO_ST_IDLE && issue_valid_i |=> op_ff == $past(instr_i[20:18]))
	else $error("operation field wrong");
AST_DM_WAY: assert property (@(posedge clk_i) disable iff (reset_i)
	$past(direct_mapped_i) && !$past(reset_i) |-> ctl_way_o == 2'h0)
	else $error("way used on direct-mapped cache");
AST_INDEX_BITS: assert property (@(posedge clk_i) disable iff (reset_i)
	!$past(reset_i) |-> ctl_index_o == $past(sel_addr[12:5]))
	else $error("index bits wrong");
AST_NO_TAG_CERR: assert property (@(posedge clk_i) disable iff (reset_i)
	exc_valid_o && (ctl_op_o == 3'h1 || ctl_op_o == 3'h2) |-> exc_code_o != cmo_pkg::CMO_EXC_CACHE_ERR)
	else $error("cache error on tag operation");
AST_BCAST_HIT: assert property (@(posedge clk_i) disable iff (reset_i)
	ctl_req_o && ctl_index_mode_o |-> !ctl_broadcast_o)
	else $error("index operation broadcast");
AST_WB_KEEP: assert property (@(posedge clk_i) disable iff (reset_i)
	ctl_req_o |-> ctl_keep_valid_o == (ctl_op_o == 3'h6 && $past(wb_data_cache_i)))
	else $error("keep-valid on wrong operation");
AST_DONE_BARRIER: assert property (@(posedge clk_i) disable iff (reset_i)
	done_o |-> $past(barrier_idle_i) && $past(state_ff) == cmo_pkg::CMO_ST_DONE)
	else $error("retired before traffic drained");
AST_EXC_KIND: assert property (@(posedge clk_i) disable iff (reset_i)
	exc_valid_o |-> exc_code_o inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5})
	else $error("illegal exception kind");
// A suppressed cache error on a tag operation ends the instruction with no pulse
AST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
	busy_o && !done_o && !exc_valid_o |=> busy_o || done_o || exc_valid_o ||
		($past(ctl_cache_err_i) && ctl_no_cache_err_o))
	else $error("instruction dropped");

COV_HIT_DONE: cover property (@(posedge clk_i) disable iff (reset_i) done_o && !ctl_index_mode_o);
COV_INNER_FIRST: cover property (@(posedge clk_i) disable iff (reset_i) ctl_req_o && ctl_target_o == 2'h1 && tgt_ff[1]);
COV_TLB_EXC: cover property (@(posedge clk_i) disable iff (reset_i) exc_valid_o && exc_code_o == cmo_pkg::CMO_EXC_TLB_REFILL);
COV_BCAST: cover property (@(posedge clk_i) disable iff (reset_i) ctl_req_o && ctl_broadcast_o);

endmodule

// ==== verification/cmo_far_model.sv ====
// Far-side model: MMU, cache controller and barrier drain
module cmo_far_model (
	input wire logic clk_i, // Core clock
	input wire logic reset_i, // Sync reset
	input wire logic mmu_req_i, // Translation asked
	input wire logic [31:0] mmu_va_i, // Address to translate
	input wire logic ctl_req_i, // Controller request
	input wire logic [2:0] cca_i, // Attribute to return
	input wire logic [1:0] fault_i, // 1 refill, 2 invalid, 3 kernel
	input wire logic [1:0] err_i, // 1 cache error, 2 bus error
	input wire logic slow_i, // Late answers, slow drain
	output logic mmu_done_o, // Translation answer
	output logic [31:0] mmu_pa_o, // Physical address
	output logic mmu_refill_o, // Miss
	output logic mmu_invalid_o, // Invalid entry
	output logic [2:0] mmu_cca_o, // Attribute
	output logic kernel_fault_o, // Faulting region
	output logic ctl_done_o, // Request done
	output logic ctl_cache_err_o, // Cache error
	output logic ctl_bus_err_o, // Bus error
	output logic barrier_idle_o // Traffic drained
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_ff;
	logic [3:0] drain_ff;
	logic any_ans;
	logic ans_m;
	logic ans_c;
	assign any_ans = mmu_done_o || ctl_done_o || ctl_cache_err_o || ctl_bus_err_o;
	assign ans_m = mmu_req_i && !any_ans && cnt_ff == (slow_i ? 4'h5 : 4'h0);
	assign ans_c = ctl_req_i && !any_ans && cnt_ff == (slow_i ? 4'h5 : 4'h0);
	always_ff @(posedge clk_i) begin
		if (reset_i || !(mmu_req_i || ctl_req_i) || ans_m || ans_c || any_ans) begin
			cnt_ff <= 4'h0;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
	// Qualifiers toggle outside an answer so stale values are never mistaken for valid ones
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			{mmu_done_o, mmu_pa_o, mmu_refill_o, mmu_invalid_o, mmu_cca_o, kernel_fault_o} <= '0;
			{ctl_done_o, ctl_cache_err_o, ctl_bus_err_o, barrier_idle_o, drain_ff} <= '0;
		end else begin
			mmu_done_o <= ans_m;
			mmu_pa_o <= ans_m ? mmu_va_i ^ 32'hA000_0000 : ~mmu_pa_o;
			mmu_refill_o <= ans_m ? fault_i == 2'h1 : ~mmu_refill_o;
			mmu_invalid_o <= ans_m ? fault_i == 2'h2 : ~mmu_invalid_o;
			kernel_fault_o <= ans_m ? fault_i == 2'h3 : ~kernel_fault_o;
			mmu_cca_o <= ans_m ? cca_i : ~mmu_cca_o;
			ctl_done_o <= ans_c && err_i == 2'h0;
			ctl_cache_err_o <= ans_c && err_i == 2'h1;
			ctl_bus_err_o <= ans_c && err_i == 2'h2;
			drain_ff <= ans_c ? (slow_i ? 4'h5 : 4'h0) : drain_ff - {3'h0, drain_ff != 4'h0};
			barrier_idle_o <= !ans_c && drain_ff == 4'h0;
		end
	end
endmodule

// ==== verification/cmo_unit_tb_top.sv ====
// Testbench for the cache maintenance operation unit
module cmo_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [2:0] op; logic [1:0] tgt; logic [15:0] imm; logic [31:0] base;
		logic phys; logic [2:0] cca; logic [31:0] addr; logic bc;} cmo_row_t;
	typedef struct packed {logic [2:0] op; logic [1:0] tgt; logic [31:0] addr; logic [1:0] way;
		logic [7:0] idx; logic im; logic bc; logic kv; logic nce;} cmo_req_t;
	logic clk_i, reset_i, issue_valid_i, phys_cache_i, direct_mapped_i, wb_data_cache_i, kernel_fault_i;
	logic [31:0] instr_i, base_value_i, mmu_pa_i, mmu_va_o, ctl_addr_o;
	logic mmu_done_i, mmu_refill_i, mmu_invalid_i, ctl_done_i, ctl_cache_err_i, ctl_bus_err_i, barrier_idle_i;
	logic [2:0] mmu_cca_i, ctl_op_o, exc_code_o, cca, exc_c;
	logic busy_o, mmu_req_o, ctl_req_o, ctl_index_mode_o, ctl_broadcast_o, ctl_keep_valid_o;
	logic ctl_no_cache_err_o, watch_hit_o, done_o, exc_valid_o, slow;
	logic [1:0] ctl_target_o, ctl_way_o, fault, err;
	logic [7:0] ctl_index_o;
	cmo_req_t lg [4];
	int err_count, n_tests, cyc, n_req, exc_n, done_n, gap;
	int ei[5] = '{6, 6, 1, 2, 8};
	int ec[5] = '{4, 5, 0, 0, 4};
	// Index rows use unmapped kernel addresses
	cmo_row_t rows[10] = '{
		'{3'h0, 2'h0, 16'hFFFC, 32'h8000_1235, 1'b0, 3'h5, 32'h8000_1231, 1'b0},
		'{3'h1, 2'h1, 16'h0021, 32'h8000_3FE0, 1'b1, 3'h5, 32'h8000_4001, 1'b0},
		'{3'h2, 2'h1, 16'h8020, 32'h8001_6000, 1'b0, 3'h4, 32'h8000_E020, 1'b0},
		'{3'h3, 2'h1, 16'h0007, 32'h0040_0000, 1'b1, 3'h4, 32'hA040_0007, 1'b0},
		'{3'h4, 2'h0, 16'h0010, 32'h1000_0000, 1'b0, 3'h4, 32'h1000_0010, 1'b1},
		'{3'h5, 2'h1, 16'hFFF0, 32'h2000_0000, 1'b1, 3'h5, 32'hBFFF_FFF0, 1'b1},
		'{3'h6, 2'h1, 16'h0003, 32'h3000_0100, 1'b1, 3'h2, 32'h9000_0103, 1'b0},
		'{3'h7, 2'h0, 16'h0040, 32'h0000_1000, 1'b0, 3'h3, 32'h0000_1040, 1'b0},
		'{3'h4, 2'h3, 16'h0000, 32'h4000_0020, 1'b1, 3'h4, 32'hE000_0020, 1'b1},
		'{3'h6, 2'h2, 16'h0001, 32'h5000_0000, 1'b0, 3'h0, 32'h5000_0001, 1'b0}};
	cmo_unit DUT (.clk_i, .reset_i, .issue_valid_i, .instr_i, .base_value_i, .phys_cache_i, .direct_mapped_i,
		.wb_data_cache_i, .kernel_fault_i, .mmu_done_i, .mmu_pa_i, .mmu_refill_i, .mmu_invalid_i, .mmu_cca_i,
		.ctl_done_i, .ctl_cache_err_i, .ctl_bus_err_i, .barrier_idle_i, .busy_o, .mmu_req_o, .mmu_va_o,
		.ctl_req_o, .ctl_op_o, .ctl_target_o, .ctl_addr_o, .ctl_way_o, .ctl_index_o, .ctl_index_mode_o,
		.ctl_broadcast_o, .ctl_keep_valid_o, .ctl_no_cache_err_o, .watch_hit_o, .done_o, .exc_valid_o,
		.exc_code_o);
	cmo_far_model far (.clk_i(clk_i), .reset_i(reset_i), .mmu_req_i(mmu_req_o), .mmu_va_i(mmu_va_o),
		.ctl_req_i(ctl_req_o), .cca_i(cca), .fault_i(fault), .err_i(err), .slow_i(slow),
		.mmu_done_o(mmu_done_i), .mmu_pa_o(mmu_pa_i), .mmu_refill_o(mmu_refill_i),
		.mmu_invalid_o(mmu_invalid_i), .mmu_cca_o(mmu_cca_i), .kernel_fault_o(kernel_fault_i),
		.ctl_done_o(ctl_done_i), .ctl_cache_err_o(ctl_cache_err_i), .ctl_bus_err_o(ctl_bus_err_i),
		.barrier_idle_o(barrier_idle_i));
	always #20 clk_i = ~clk_i;
	task automatic complete_run();
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Issues one instruction and logs every controller request taken until busy drops
	task automatic run(input cmo_row_t r, input logic [1:0] f, input logic [1:0] e, input logic dm,
		input logic sl);
		int k;
		int last;
		n_req = 0;
		exc_n = 0;
		done_n = 0;
		last = 0;
		@(posedge clk_i);
		issue_valid_i <= 1'b1;
		instr_i <= {6'h2F, 5'h04, r.op, r.tgt, r.imm};
		base_value_i <= r.base;
		phys_cache_i <= r.phys;
		cca <= r.cca;
		fault <= f;
		err <= e;
		direct_mapped_i <= dm;
		slow <= sl;
		// Next issue only after busy drops, which on retirement waits for the barrier drain
		for (k = 1; k < 80; k++) begin
			@(posedge clk_i);
			issue_valid_i <= 1'b0;
			#1;
			chk(watch_hit_o, 0);
			if (ctl_req_o && (ctl_done_i || ctl_cache_err_i || ctl_bus_err_i) && n_req < 4) begin
				lg[n_req] = {ctl_op_o, ctl_target_o, ctl_addr_o, ctl_way_o, ctl_index_o, ctl_index_mode_o,
					ctl_broadcast_o, ctl_keep_valid_o, ctl_no_cache_err_o};
				n_req++;
				last = k;
			end
			if (exc_valid_o) begin
				exc_n++;
				exc_c = exc_code_o;
			end
			if (done_o) begin
				done_n++;
				gap = k - last;
			end
			if (busy_o === 1'b0) break;
		end
		chk(busy_o, 0);
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		int i;
		int j;
		{clk_i, issue_valid_i, phys_cache_i, direct_mapped_i, slow, instr_i, base_value_i} = '0;
		{cca, fault, err} = '0;
		wb_data_cache_i = 1'b1;
		reset_i = 1'b1;
		repeat (6) @(posedge clk_i);
		#1;
		chk({busy_o, mmu_req_o, ctl_req_o, done_o, exc_valid_o}, 0);
		@(posedge clk_i);
		reset_i <= 1'b0;
		for (i = 0; i < 10; i++) begin
			run(rows[i], 2'h0, 2'h0, 1'b0, 1'b0);
			chk(n_req, rows[i].tgt[1] ? 2 : 1);
			chk({done_n, exc_n}, {32'h1, 32'h0});
			for (j = 0; j < n_req; j++) begin
				chk(lg[j].tgt, (j == 0 && rows[i].tgt[1]) ? 1 : rows[i].tgt);
				chk(lg[j].op, rows[i].op);
				chk(lg[j].addr, rows[i].addr);
				chk({lg[j].way, lg[j].idx}, rows[i].addr[14:5]);
				chk(lg[j].im, rows[i].op < 3);
				chk(lg[j].bc, rows[i].bc);
				chk(lg[j].nce, rows[i].op == 1 || rows[i].op == 2);
				if (lg[j].tgt == 2'h1) chk(lg[j].kv, rows[i].op == 6);
			end
		end
		for (i = 1; i < 4; i++) begin
			run(rows[5], i[1:0], 2'h0, 1'b0, 1'b0);
			chk({exc_n, done_n, n_req}, {32'h1, 32'h0, 32'h0});
			chk(exc_c, i);
		end
		for (i = 0; i < 5; i++) begin
			run(rows[ei[i]], 2'h0, i == 1 ? 2'h2 : 2'h1, 1'b0, 1'b0);
			chk(exc_n, ec[i] != 0);
			if (ec[i] != 0) chk(exc_c, ec[i]);
			chk(n_req, 1);
		end
		run(rows[2], 2'h0, 2'h0, 1'b1, 1'b0);
		chk({lg[0].way, lg[0].idx}, {2'h0, rows[2].addr[12:5]});
		wb_data_cache_i <= 1'b0;
		run(rows[6], 2'h0, 2'h0, 1'b0, 1'b0);
		chk(lg[0].kv, 0);
		wb_data_cache_i <= 1'b1;
		run(rows[8], 2'h0, 2'h0, 1'b0, 1'b1);
		chk({n_req, done_n}, {32'h2, 32'h1});
		chk(lg[1].addr, rows[8].addr);
		chk(gap >= 7, 1);
		// Reset in the middle of a slow translation
		@(posedge clk_i);
		issue_valid_i <= 1'b1;
		@(posedge clk_i);
		issue_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b1;
		#1;
		chk(busy_o, 1);
		repeat (2) @(posedge clk_i);
		#1;
		chk({busy_o, mmu_req_o, ctl_req_o, done_o, exc_valid_o}, 0);
		@(posedge clk_i);
		reset_i <= 1'b0;
		run(rows[0], 2'h0, 2'h0, 1'b0, 1'b0);
		chk({n_req, done_n, exc_n}, {32'h1, 32'h1, 32'h0});
		complete_run();
	end
endmodule
